// ===== txfr_consts.vh
// Constants for the transmit input realignment FIFO.
// Included by bare name from the design file; definitions only.
`ifndef TXFR_CONSTS_VH
`define TXFR_CONSTS_VH

`define TXFR_DATA_W 16
`define TXFR_BANKS 6
`define TXFR_BANK_AW 3
`define TXFR_BANK_CNT 3'h6
`define TXFR_CENTRE 3'h3
`define TXFR_NEAR_LO 3'h1
`define TXFR_NEAR_HI 3'h5
`define TXFR_BUF_DEPTH 16
`define TXFR_BUF_AW 4
`define TXFR_DIV_W 4
`define TXFR_DIV_LAST 4'hF
`define TXFR_LOCK_EDGES 2'h3
`define TXFR_REQ_HOLD 3'h2
`define TXFR_INIT_WAIT 3'h2
`define TXFR_PTR_RST 3'h0
`define TXFR_CLK_PERIOD_PS 10000
`define TXFR_DRIFT_PS 5200

`endif

// ===== txfr_realign.v
// Transmit input FIFO: 16-bit words written on input-clock edges, read on
// the internal divide-by-16 byte-clock enable, then queued in a 16-word
// buffer for the serializer. Assumes every input is synchronous to mclk
// and that the input clock is at least four times slower than mclk.
//
// How it works
// - Lock indicator rises once the transmit PLL reports lock after reset.
// - Third input-clock rising edge after lock initializes the FIFO automatically.
// - Any byte-clock to input-clock delay is accepted, captured at initialization.
// - Phase fault flag rises when read and write pointers come too close.
// - Phase fault flag stays high until the next initialization, even after the mismatch clears.
// - Realign request high two byte clocks initializes FIFO two byte clocks later.
// - Phase fault flag falls when initialization completes.
// - A realign request shorter than two byte clocks is ignored.
// - Forward mode locks the byte-clock load strobe to the reference clock.
// - FIFO is sixteen bits wide, six banks deep, written and read as described.
// - Each written bank is read exactly once by the byte clock unless the output buffer stalls.
// - A looped-back realignment may discard one to three words.
`timescale 1ns/10ps
`include "txfr_consts.vh"

module txfr_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign inReady = (cnt_r != DEPTH[AW:0]);
    assign outValid = (cnt_r != {(AW+1){1'b0}});
    assign outData = mem[rp_r];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always @(posedge mclk) begin
        if (push) begin
            mem[wp_r] <= inData;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= ({1'b0, wp_r} == DEPTH[AW:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= ({1'b0, rp_r} == DEPTH[AW:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // txfr_fifo

module txfr_realign (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // PLL and reference
    input wire pllLocked,
    input wire txReferenceClock,
    input wire forwardClockMode,
    output reg pllLockFlag,
    // Byte clock out
    output reg byteClockOut,
    // Parallel input from partner
    input wire txInputClock,
    input wire [15:0] txData,
    // Realign handshake
    input wire realignRequest,
    output reg phaseFaultFlag,
    // Stream toward the serializer
    output wire outValid,
    input wire outReady,
    output wire [15:0] outData
);
    reg [`TXFR_DATA_W-1:0] bank [0:`TXFR_BANKS-1];
    reg [`TXFR_DIV_W-1:0] div_r;
    reg icPrev_r;
    reg refPrev_r;
    reg lockPrev_r;
    reg [1:0] lockEdges_r;
    reg autoArmed_r;
    reg [`TXFR_BANK_AW-1:0] wrPtr_r;
    reg [`TXFR_BANK_AW-1:0] rdPtr_r;
    reg running_r;
    reg [2:0] reqCnt_r;
    reg reqUsed_r;
    reg waitOn_r;
    reg [2:0] waitCnt_r;
    reg [`TXFR_DATA_W-1:0] rdData_r;
    reg rdValid_r;
    wire icEdge;
    wire refEdge;
    wire byteEn;
    wire autoInit;
    wire reqInit;
    wire doInit;
    wire nearMiss;
    wire bufReady;
    wire [`TXFR_BANK_AW-1:0] wrNext;
    wire [`TXFR_BANK_AW-1:0] gap;
    wire [`TXFR_BANK_AW-1:0] centreRd;

    function [`TXFR_BANK_AW-1:0] bankInc;
        input [`TXFR_BANK_AW-1:0] p;
        begin
            bankInc = (p == `TXFR_BANKS - 1) ? `TXFR_PTR_RST : p + 1'b1;
        end
    endfunction

    assign icEdge = txInputClock & ~icPrev_r;
    assign refEdge = txReferenceClock & ~refPrev_r;
    assign byteEn = (div_r == `TXFR_DIV_LAST);
    assign wrNext = bankInc(wrPtr_r);
    // Distance from read to write pointer, modulo the bank count
    assign gap = (wrPtr_r >= rdPtr_r) ? wrPtr_r - rdPtr_r
                                      : wrPtr_r + `TXFR_BANK_CNT - rdPtr_r;
    assign nearMiss = running_r && ((gap <= `TXFR_NEAR_LO) || (gap >= `TXFR_NEAR_HI));
    assign autoInit = autoArmed_r && icEdge
                      && (lockEdges_r == `TXFR_LOCK_EDGES - 1'b1);
    assign reqInit = waitOn_r && byteEn && (waitCnt_r == `TXFR_INIT_WAIT - 1'b1);
    assign doInit = autoInit | reqInit;
    // Read pointer set half the depth behind the write side at this instant
    assign centreRd = (wrNext >= `TXFR_CENTRE) ? wrNext - `TXFR_CENTRE
                                               : wrNext + `TXFR_BANK_CNT - `TXFR_CENTRE;

    // Byte-clock divider; in forward mode its phase is pinned to the reference
    always @(posedge mclk) begin
        if (rst) begin
            div_r <= {`TXFR_DIV_W{1'b0}};
            byteClockOut <= 1'b0;
            refPrev_r <= 1'b0;
        end else begin
            refPrev_r <= txReferenceClock;
            if (forwardClockMode && refEdge) begin
                div_r <= {`TXFR_DIV_W{1'b0}};
            end else begin
                div_r <= div_r + 1'b1;
            end
            byteClockOut <= div_r[`TXFR_DIV_W-1];
        end
    end

    // Lock indicator and the automatic initialization after lock
    always @(posedge mclk) begin
        if (rst) begin
            pllLockFlag <= 1'b0;
            lockPrev_r <= 1'b0;
            lockEdges_r <= 2'h0;
            autoArmed_r <= 1'b0;
            icPrev_r <= 1'b0;
        end else begin
            icPrev_r <= txInputClock;
            pllLockFlag <= pllLocked;
            lockPrev_r <= pllLockFlag;
            if (pllLockFlag && !lockPrev_r) begin
                autoArmed_r <= 1'b1;
                lockEdges_r <= 2'h0;
            end else if (!pllLockFlag) begin
                autoArmed_r <= 1'b0;
            end else if (autoInit) begin
                autoArmed_r <= 1'b0;
            end else if (autoArmed_r && icEdge) begin
                lockEdges_r <= lockEdges_r + 1'b1;
            end
        end
    end

    // Realign request: qualified after two byte clocks, acted on two later
    always @(posedge mclk) begin
        if (rst) begin
            reqCnt_r <= 3'h0;
            reqUsed_r <= 1'b0;
            waitOn_r <= 1'b0;
            waitCnt_r <= 3'h0;
        end else begin
            if (!realignRequest) begin
                reqCnt_r <= 3'h0;
                reqUsed_r <= 1'b0;
            end else if (byteEn && !reqUsed_r) begin
                if (reqCnt_r == `TXFR_REQ_HOLD - 1'b1) begin
                    reqUsed_r <= 1'b1;
                    waitOn_r <= 1'b1;
                    waitCnt_r <= 3'h0;
                end
                reqCnt_r <= reqCnt_r + 1'b1;
            end
            if (reqInit || autoInit) begin
                waitOn_r <= 1'b0;
            end else if (waitOn_r && byteEn) begin
                waitCnt_r <= waitCnt_r + 1'b1;
            end
        end
    end

    // Bank writes on input-clock edges
    always @(posedge mclk) begin
        if (icEdge) begin
            bank[wrPtr_r] <= txData;
        end
    end

    // Pointers, bank reads and the fault flag
    always @(posedge mclk) begin
        if (rst) begin
            wrPtr_r <= `TXFR_PTR_RST;
            rdPtr_r <= `TXFR_PTR_RST;
            running_r <= 1'b0;
            phaseFaultFlag <= 1'b0;
            rdData_r <= {`TXFR_DATA_W{1'b0}};
            rdValid_r <= 1'b0;
        end else begin
            if (icEdge) begin
                wrPtr_r <= wrNext;
            end
            rdValid_r <= 1'b0;
            if (doInit) begin
                // Delay between byte clock and input clock is frozen here
                rdPtr_r <= centreRd;
                running_r <= 1'b1;
                phaseFaultFlag <= 1'b0;
            end else begin
                if (nearMiss) begin
                    phaseFaultFlag <= 1'b1;
                end
                // A stalled buffer skips a read; the drift then shows as a fault
                if (running_r && byteEn && bufReady) begin
                    rdData_r <= bank[rdPtr_r];
                    rdValid_r <= ~phaseFaultFlag;
                    rdPtr_r <= bankInc(rdPtr_r);
                end
            end
        end
    end

    txfr_fifo #(
        .WIDTH(`TXFR_DATA_W),
        .DEPTH(`TXFR_BUF_DEPTH),
        .AW(`TXFR_BUF_AW)
    ) i_txfr_fifo (
        .mclk(mclk),
        .rst(rst),
        .inValid(rdValid_r),
        .inReady(bufReady),
        .inData(rdData_r),
        .outValid(outValid),
        .outReady(outReady),
        .outData(outData)
    );
endmodule // txfr_realign

// ===== txfr_realign_monitor.sv
// Checker on the top ports of the realignment FIFO.
// Assumes forward mode is set from reset or never, so the byte clock never jumps.
`timescale 1ns/10ps
module txfr_realign_monitor (
    // Watched ports
    input wire mclk,
    input wire rst,
    input wire pllLocked,
    input wire txReferenceClock,
    input wire forwardClockMode,
    input wire pllLockFlag,
    input wire byteClockOut,
    input wire realignRequest,
    input wire phaseFaultFlag,
    input wire outValid,
    input wire outReady,
    input wire [15:0] outData
);
    reset_clear_a: assert property (@(posedge mclk)
        rst |=> !pllLockFlag && !phaseFaultFlag && !outValid) else $error("reset clear");
    lock_follow_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(pllLocked) |=> pllLockFlag) else $error("lock follow");
    lock_wait_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(pllLockFlag) && !outValid |=> !outValid [*8]) else $error("early data");
    byte_period_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(byteClockOut) |-> ##16 $rose(byteClockOut)) else $error("byte period");
    forward_phase_a: assert property (@(posedge mclk) disable iff (rst)
        forwardClockMode && $rose(txReferenceClock) |-> ##10 $rose(byteClockOut))
        else $error("forward phase");
    realign_done_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(realignRequest) |-> ##[1:70] !phaseFaultFlag) else $error("no realign");
    fault_sticky_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(phaseFaultFlag) |-> $past(realignRequest)) else $error("fault dropped");
    fault_locked_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(phaseFaultFlag) |-> pllLockFlag) else $error("fault unlocked");
    out_hold_a: assert property (@(posedge mclk) disable iff (rst)
        outValid && !outReady |=> outValid && $stable(outData)) else $error("out hold");
endmodule // txfr_realign_monitor
bind txfr_realign txfr_realign_monitor i_txfr_realign_monitor (.mclk, .rst, .pllLocked,
    .txReferenceClock, .forwardClockMode, .pllLockFlag, .byteClockOut, .realignRequest,
    .phaseFaultFlag, .outValid, .outReady, .outData);

// ===== txfr_framer_model.sv
// Framer model: input clock, counting words, realign request.
// Assumes it shares mclk with the device; input period 16 or 17 cycles.
`timescale 1ns/10ps
module txfr_framer_model (
    // Clock and reset
    input logic mclk,
    input logic rst,
    // Bench controls
    input logic slow,
    input logic loopBack,
    // Device side
    input logic phaseFaultFlag,
    output logic txInputClock,
    output logic [15:0] txData,
    output logic realignRequest
);
    logic [4:0] cnt_r;
    logic [15:0] seq_r;
    logic req_r;
    // Loop-back shorts the flag onto the request
    assign realignRequest = loopBack ? phaseFaultFlag : req_r;
    always @(posedge mclk) begin
        req_r <= phaseFaultFlag;
        if (rst) begin
            cnt_r <= 5'h0;
            seq_r <= 16'h0;
            txInputClock <= 1'b0;
        end else begin
            // Slow mode breaks the drift limit on purpose
            cnt_r <= (cnt_r == (slow ? 5'h10 : 5'h0F)) ? 5'h0 : cnt_r + 5'h1;
            txInputClock <= cnt_r < 5'h8;
            if (cnt_r == 5'h0 && !phaseFaultFlag) seq_r <= seq_r + 16'h1;
            // Idle words while faulted keep payload from being lost
            if (cnt_r == 5'h0) txData <= phaseFaultFlag ? 16'h0 : seq_r + 16'h1;
        end
    end
endmodule // txfr_framer_model

// ===== tb_txfr_realign.sv
// Testbench for txfr_realign driven by the framer model.
// Assumes the reference clock is the framer's input clock, forward mode on from reset.
`timescale 1ns/10ps
module tb_txfr_realign;
    logic mclk, rst, pllLocked, outReady, slow, loopBack, fwdMode;
    wire pllLockFlag, byteClockOut, txInputClock, realignRequest, phaseFaultFlag, outValid;
    wire [15:0] txData, outData;
    logic [15:0] w, last;
    int n_errors = 0;
    int n_compared = 0;
    int k;
    txfr_realign i_txfr_realign (.mclk, .rst, .pllLocked,
        .txReferenceClock(txInputClock),
        .forwardClockMode(fwdMode), .pllLockFlag, .byteClockOut, .txInputClock, .txData,
        .realignRequest, .phaseFaultFlag, .outValid, .outReady, .outData);
    txfr_framer_model i_txfr_framer_model (.mclk, .rst, .slow, .loopBack, .phaseFaultFlag,
        .txInputClock, .txData, .realignRequest);
    task end_sim;
        begin
            $display("Compared %0d, mismatches %0d", n_compared, n_errors);
            if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        begin
            n_compared++;
            if (got !== exp) begin
                n_errors++;
                $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wait_flag(input logic lvl, input int lim);
        int i;
        begin
            for (i = 0; i < lim && phaseFaultFlag !== lvl; i++) @(negedge mclk);
            chk("fault flag", {15'h0, lvl}, {15'h0, phaseFaultFlag});
            if (phaseFaultFlag !== lvl) end_sim;
        end
    endtask
    task pop(output logic [15:0] v);
        int i;
        begin
            @(negedge mclk);
            for (i = 0; i < 400 && outValid !== 1'b1; i++) @(negedge mclk);
            chk("out valid", 16'h1, {15'h0, outValid});
            if (outValid !== 1'b1) end_sim;
            v = outData;
            @(posedge mclk) outReady <= 1'b1;
            @(posedge mclk) outReady <= 1'b0;
        end
    endtask
    task t_stream;
        begin
            chk("lock flag", 16'h0, {15'h0, pllLockFlag});
            @(posedge mclk) pllLocked <= 1'b1;
            @(negedge mclk);
            chk("lock flag", 16'h0, {15'h0, pllLockFlag});
            @(negedge mclk);
            chk("lock flag", 16'h1, {15'h0, pllLockFlag});
            pop(last);
            for (k = 1; k < 8; k++) begin
                pop(w);
                chk("stream word", last + 16'h1, w);
                last = w;
            end
            $display("t_stream done");
        end
    endtask
    task t_fill;
        begin
            repeat (600) @(posedge mclk);
            @(negedge mclk);
            chk("out valid", 16'h1, {15'h0, outValid});
            for (k = 1; k <= 16; k++) begin
                pop(w);
                chk("held word", last + 16'h1, w);
                last = w;
            end
            wait_flag(1'b0, 300);
            $display("t_fill done");
        end
    endtask
    task t_drift;
        begin
            // Forward mode would pin the byte clock to the slowed input clock
            @(posedge mclk) fwdMode <= 1'b0;
            @(posedge mclk);
            loopBack <= 1'b1;
            outReady <= 1'b1;
            slow <= 1'b1;
            wait_flag(1'b1, 3000);
            wait_flag(1'b0, 200);
            @(posedge mclk);
            slow <= 1'b0;
            outReady <= 1'b0;
            $display("t_drift done");
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        pllLocked = 1'b0;
        outReady = 1'b0;
        slow = 1'b0;
        loopBack = 1'b0;
        // On from reset, so the first reference edge causes no byte-clock jump
        fwdMode = 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_stream;
        t_fill;
        t_drift;
        end_sim;
    end
endmodule // tb_txfr_realign
